// ### graphics_slave_host_port.sv
`timescale 1ns/100ps
`include "gshp_map.svh"
module gshp_graphics_slave_host_port
  import gshp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire gshp_addr_t addrIn,
  input wire logic byte_high_enable_n,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic mem_or_io_select,
  input wire logic csN,
  input wire logic [15:0] dataIn,
  input wire logic masterMode,
  input wire gshp_addr_t relocBase,
  input wire logic relocIsMem,
  input wire logic bus_width_select,
  input wire logic grantIn,
  input wire logic memDoneIn,
  input wire logic [15:0] memRdData,
  input wire logic [15:0] regRdData,
  output logic slave_enable,
  output logic slaveReqOut,
  output logic low_lane_store_en_n,
  output logic high_lane_store_en_n,
  output logic regWrOut,
  output logic [`GSHP_REG_IDX_W-1:0] regIdxOut,
  output logic [15:0] regWrData,
  output logic [15:0] dataOut,
  output logic dataOutEnN,
  output logic pinOutEnN
);
  gshp_cmd_if cmd ();
  gshp_decode u_dec (
    .cmd(cmd),
    .rdN(rdN),
    .wrN(wrN),
    .csN(csN),
    .memOrIo(mem_or_io_select),
    .masterMode(masterMode),
    .addr(addrIn),
    .relocBase(relocBase),
    .relocIsMem(relocIsMem)
  );
  gshp_state_e state_ff, nxt_state;
  logic [1:0] waitCnt_ff, nxt_waitCnt;
  logic armed_ff;
  logic latchValid_ff;
  logic [7:0] lowLatch_ff;
  logic [15:0] wrData_ff;
  logic isWr_ff, isReg_ff, a0_ff, bhe_ff;
  gshp_addr_t offs_ff;
  wire gshp_addr_t offsNow;
  wire waitDone;
  wire start;
  wire eightBit;
  wire hiByteWr;
  wire loByteWr;
  wire doRegWr;
  wire [15:0] wordWr;
  wire [`GSHP_REG_IDX_W-1:0] idxNow;
  wire lowEnN;
  wire highEnN;
  assign offsNow = addrIn - {relocBase[21:1], 1'b0};
  assign eightBit = !bus_width_select;
  assign start = cmd.valid && armed_ff;
  assign waitDone = isWr_ff ? (waitCnt_ff == 2'(`GSHP_WR_WAIT - 1))
    : (isReg_ff ? (waitCnt_ff == 2'(`GSHP_RD_WAIT - 1)) : memDoneIn);
  assign loByteWr = eightBit && !a0_ff;
  assign hiByteWr = eightBit && a0_ff;
  assign doRegWr = isWr_ff && isReg_ff && waitDone && (state_ff == GSHP_WAIT)
    && (!eightBit || (hiByteWr && latchValid_ff));
  assign wordWr = eightBit ? {wrData_ff[15:8], lowLatch_ff}
    : wrData_ff;
  assign idxNow = offs_ff[`GSHP_REG_IDX_W:1];
  assign lowEnN = !(a0_ff == 1'b0);
  assign highEnN = bhe_ff;
  always_comb
  begin
    nxt_state = state_ff;
    nxt_waitCnt = waitCnt_ff;
    case (state_ff)
      GSHP_IDLE:
      begin
        nxt_waitCnt = 2'h0;
        if (start && cmd.ioMiss)
          nxt_state = GSHP_DUMMY;
        else if (start)
          nxt_state = GSHP_ARB;
      end
      GSHP_ARB:
        if (grantIn)
          nxt_state = GSHP_WAIT;
      GSHP_WAIT:
      begin
        nxt_waitCnt = waitCnt_ff + 2'h1;
        if (waitDone)
          nxt_state = GSHP_DONE;
      end
      GSHP_DUMMY:
      begin
        nxt_waitCnt = waitCnt_ff + 2'h1;
        if (waitCnt_ff == 2'(`GSHP_DUMMY_CYC - 1))
          nxt_state = GSHP_IDLE;
      end
      GSHP_DONE:
        nxt_state = GSHP_IDLE;
      default:
        nxt_state = GSHP_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= GSHP_IDLE;
      waitCnt_ff <= 2'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      waitCnt_ff <= nxt_waitCnt;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed_ff <= 1'b1;
    else if (start)
      armed_ff <= 1'b0;
    else if (rdN && wrN)
      armed_ff <= 1'b1;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      isWr_ff <= 1'b0;
      isReg_ff <= 1'b0;
      a0_ff <= 1'b0;
      bhe_ff <= 1'b1;
      offs_ff <= 22'h000000;
      wrData_ff <= 16'h0000;
    end
    else if (start)
    begin
      isWr_ff <= cmd.isWrite;
      isReg_ff <= cmd.hitReg;
      a0_ff <= addrIn[0];
      bhe_ff <= byte_high_enable_n;
      offs_ff <= offsNow;
      wrData_ff <= dataIn;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latchValid_ff <= 1'b0;
      lowLatch_ff <= 8'h00;
    end
    else if (isWr_ff && isReg_ff && waitDone && state_ff == GSHP_WAIT)
    begin
      if (loByteWr)
      begin
        lowLatch_ff <= wrData_ff[7:0];
        latchValid_ff <= 1'b1;
      end
      else
        latchValid_ff <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slave_enable <= 1'b0;
      slaveReqOut <= 1'b0;
      low_lane_store_en_n <= 1'b1;
      high_lane_store_en_n <= 1'b1;
      regWrOut <= 1'b0;
      regIdxOut <= '0;
      regWrData <= 16'h0000;
      dataOut <= 16'h0000;
      dataOutEnN <= 1'b1;
      pinOutEnN <= 1'b1;
    end
    else
    begin
      slaveReqOut <= (nxt_state == GSHP_ARB);
      slave_enable <= (nxt_state == GSHP_WAIT) || (nxt_state == GSHP_DONE);
      low_lane_store_en_n <= !(state_ff == GSHP_WAIT && isWr_ff && !isReg_ff
        && !lowEnN);
      high_lane_store_en_n <= !(state_ff == GSHP_WAIT && isWr_ff && !isReg_ff
        && !highEnN);
      regWrOut <= doRegWr;
      regIdxOut <= idxNow;
      regWrData <= wordWr;
      dataOut <= isReg_ff ? regRdData : memRdData;
      dataOutEnN <= !((nxt_state == GSHP_WAIT || nxt_state == GSHP_DONE)
        && !isWr_ff);
      pinOutEnN <= !masterMode;
    end
  end
endmodule

// ### gshp_checker.sv
`timescale 1ns/100ps
module gshp_checker
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic grantIn,
  input wire logic masterMode,
  input wire logic slave_enable,
  input wire logic slaveReqOut,
  input wire logic regWrOut,
  input wire logic low_lane_store_en_n,
  input wire logic high_lane_store_en_n,
  input wire logic pinOutEnN,
  input wire logic dataOutEnN
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_REQ: assert property ($rose(slaveReqOut) |-> !$past(csN))
    else $error("request without select");
  AST_GNT: assert property ($rose(slave_enable) |->
    $past(grantIn) || $past(grantIn, 2)) else $error("ack without grant");
  AST_ACK: assert property ($rose(slave_enable) |->
    !csN && !(rdN && wrN)) else $error("ack without command");
  AST_WAIT: assert property ($rose(slave_enable) && !wrN |->
    slave_enable[*3]) else $error("write ack too short");
  AST_PULSE: assert property (regWrOut |=> !regWrOut)
    else $error("register write not a pulse");
  AST_LANE: assert property (!low_lane_store_en_n ||
    !high_lane_store_en_n |-> slave_enable) else $error("store outside ack");
  AST_DOE: assert property (!dataOutEnN |-> slave_enable)
    else $error("read data driven outside ack");
  AST_PIN: assert property (masterMode[*2] |-> !pinOutEnN)
    else $error("pins not driven in master mode");
  AST_MST: assert property (masterMode[*2] |-> !$rose(slaveReqOut))
    else $error("request in master mode");
endmodule
bind gshp_graphics_slave_host_port gshp_checker chk (.clk, .rst_n, .csN,
  .rdN, .wrN, .grantIn, .masterMode, .slave_enable, .slaveReqOut, .regWrOut,
  .low_lane_store_en_n, .high_lane_store_en_n, .pinOutEnN, .dataOutEnN);

// ### gshp_cmd_if.sv
`timescale 1ns/100ps
interface gshp_cmd_if;
  logic valid;
  logic isWrite;
  logic isMem;
  logic hitReg;
  logic ioMiss;
  modport dec (output valid, isWrite, isMem, hitReg, ioMiss);
  modport use_ (input valid, isWrite, isMem, hitReg, ioMiss);
endinterface

// ### gshp_decode.sv
`timescale 1ns/100ps
`include "gshp_map.svh"
module gshp_decode
  import gshp_pkg::*;
(
  gshp_cmd_if.dec cmd,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic csN,
  input wire logic memOrIo,
  input wire logic masterMode,
  input wire gshp_addr_t addr,
  input wire gshp_addr_t relocBase,
  input wire logic relocIsMem
);
  wire cmdOk;
  wire inBlock;
  wire gshp_addr_t offs;
  assign offs = addr - {relocBase[21:1], 1'b0};
  assign inBlock = offs < `GSHP_REG_SPAN;
  assign cmdOk = !csN && !masterMode && (rdN ^ wrN);
  assign cmd.valid = cmdOk && (memOrIo || !relocIsMem);
  assign cmd.isWrite = !wrN;
  assign cmd.isMem = memOrIo;
  assign cmd.hitReg = inBlock && (memOrIo == relocIsMem);
  assign cmd.ioMiss = !memOrIo && !relocIsMem && !inBlock;
endmodule

// ### gshp_host_model.sv
`timescale 1ns/100ps
module gshp_host_model
  import gshp_pkg::*;
(
  input wire logic clk,
  input wire logic slave_enable,
  input wire logic [15:0] dataOut,
  output gshp_addr_t addrIn,
  output logic byte_high_enable_n,
  output logic rdN,
  output logic wrN,
  output logic mem_or_io_select,
  output logic csN,
  output logic [15:0] dataIn
);
  initial
  begin
    {addrIn, byte_high_enable_n, rdN, wrN, mem_or_io_select, csN} = '1;
    dataIn = '1;
  end
  task automatic xfer(input logic w, m, input gshp_addr_t a,
    input logic [15:0] d, output logic got, output logic [15:0] q);
    int n;
    got = 1'b0;
    @(posedge clk);
    addrIn <= a;
    byte_high_enable_n <= ~a[0];
    mem_or_io_select <= m;
    dataIn <= d;
    {rdN, wrN} <= {w, ~w};
    csN <= 1'b0;
    for (n = 0; n < 20 && !got; n++)
    begin
      @(negedge clk);
      got = slave_enable;
      q = dataOut;
    end
    @(posedge clk);
    {rdN, wrN, csN} <= 3'h7;
    addrIn <= ~a;
    dataIn <= ~d;
    @(negedge clk);
    for (n = 0; n < 20 && slave_enable; n++)
      @(negedge clk);
    @(posedge clk);
  endtask
endmodule

// ### gshp_map.svh
`ifndef GSHP_MAP_SVH
`define GSHP_MAP_SVH
`define GSHP_ADDR_W 22
`define GSHP_REG_SPAN 22'h000080
`define GSHP_REG_IDX_W 6
`define GSHP_WR_WAIT 2
`define GSHP_RD_WAIT 2
`define GSHP_DUMMY_CYC 2
`endif

// ### gshp_pkg.sv
package gshp_pkg;
  typedef enum logic [4:0] {
    GSHP_IDLE = 5'h01,
    GSHP_ARB = 5'h02,
    GSHP_WAIT = 5'h04,
    GSHP_DONE = 5'h08,
    GSHP_DUMMY = 5'h10
  } gshp_state_e;
  typedef logic [21:0] gshp_addr_t;
endpackage

// ### test_gshp_graphics_slave_host_port.sv
`timescale 1ns/100ps
`include "gshp_map.svh"
module test_gshp_graphics_slave_host_port
  import gshp_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic masterMode = 1'b0;
  logic bus_width_select = 1'b0;
  logic grantIn = 1'b0;
  logic memDoneIn = 1'b0;
  logic relocIsMem = 1'b0;
  gshp_addr_t relocBase = 22'h000400;
  logic [15:0] memRdData = 16'h1234;
  logic [15:0] regRdData = 16'h5a5a;
  gshp_addr_t addrIn;
  logic byte_high_enable_n, rdN, wrN, mem_or_io_select, csN, g;
  logic slave_enable, slaveReqOut, low_lane_store_en_n, high_lane_store_en_n;
  logic regWrOut, dataOutEnN, pinOutEnN;
  logic [`GSHP_REG_IDX_W-1:0] regIdxOut, lastIdx;
  logic [15:0] dataIn, dataOut, regWrData, lastWd, q;
  logic [1:0] lanes = 2'h0;
  int nWr = 0;
  int num_errors = 0;
  int n_checks = 0;
  gshp_graphics_slave_host_port uut (.clk, .rst_n, .addrIn,
    .byte_high_enable_n, .rdN, .wrN, .mem_or_io_select, .csN, .dataIn,
    .masterMode, .relocBase, .relocIsMem, .bus_width_select, .grantIn,
    .memDoneIn, .memRdData, .regRdData, .slave_enable, .slaveReqOut,
    .low_lane_store_en_n, .high_lane_store_en_n, .regWrOut, .regIdxOut,
    .regWrData, .dataOut, .dataOutEnN, .pinOutEnN);
  gshp_host_model host (.clk, .slave_enable, .dataOut, .addrIn,
    .byte_high_enable_n, .rdN, .wrN, .mem_or_io_select, .csN, .dataIn);
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    grantIn <= slaveReqOut;
    memDoneIn <= grantIn;
    lanes <= lanes | {~high_lane_store_en_n, ~low_lane_store_en_n};
    if (regWrOut === 1'b1)
    begin
      nWr <= nWr + 1;
      lastIdx <= regIdxOut;
      lastWd <= regWrData;
    end
  end
  task automatic chk(input string s, input logic [15:0] e, v);
    n_checks++;
    if (v !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", s, e, v);
    end
  endtask
  task automatic clr;
    @(negedge clk);
    nWr = 0;
    lanes = 2'h0;
  endtask
  task automatic t_pair;
    clr;
    host.xfer(1'b1, 1'b0, 22'h000412, 16'hee11, g, q);
    host.xfer(1'b1, 1'b0, 22'h000412, 16'hdd22, g, q);
    host.xfer(1'b1, 1'b0, 22'h000413, 16'h33cc, g, q);
    chk("ack", 16'h1, {15'h0, g});
    chk("writes", 16'h1, nWr[15:0]);
    chk("index", 16'h9, {10'h0, lastIdx});
    chk("word", 16'h3322, lastWd);
    clr;
    host.xfer(1'b1, 1'b0, 22'h000413, 16'h4400, g, q);
    host.xfer(1'b1, 1'b0, 22'h000412, 16'h0055, g, q);
    chk("locked", 16'h0, nWr[15:0]);
  endtask
  task automatic t_refuse;
    clr;
    host.xfer(1'b1, 1'b0, 22'h000100, 16'h1111, g, q);
    chk("miss ack", 16'h0, {15'h0, g});
    chk("miss lanes", 16'h0, {14'h0, lanes});
    @(posedge clk);
    masterMode <= 1'b1;
    host.xfer(1'b1, 1'b0, 22'h000413, 16'h2200, g, q);
    chk("master ack", 16'h0, {15'h0, g});
    chk("master writes", 16'h0, nWr[15:0]);
    @(posedge clk);
    masterMode <= 1'b0;
  endtask
  task automatic t_word;
    @(posedge clk);
    bus_width_select <= 1'b1;
    clr;
    host.xfer(1'b1, 1'b0, 22'h000415, 16'habcd, g, q);
    chk("writes", 16'h1, nWr[15:0]);
    chk("index", 16'ha, {10'h0, lastIdx});
    chk("word", 16'habcd, lastWd);
    host.xfer(1'b0, 1'b0, 22'h000410, 16'h0, g, q);
    chk("read", 16'h5a5a, q);
  endtask
  task automatic t_mem;
    clr;
    host.xfer(1'b1, 1'b1, 22'h001001, 16'h7700, g, q);
    chk("lanes", 16'h2, {14'h0, lanes});
    clr;
    host.xfer(1'b0, 1'b1, 22'h001001, 16'h0, g, q);
    chk("rd lanes", 16'h0, {14'h0, lanes});
    chk("mem read", 16'h1234, q);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_pair;
    t_refuse;
    t_word;
    t_mem;
    complete_run;
  end
endmodule
